/* File: smcr_master.sv */
// partner model: management bus master on the two open-drain lines
`timescale 1ns/1ps
module smcr_master (
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    // ==========================================================
    // timing: 125 ns bit in four quarter steps
    localparam realtime Q = 31.25;
    // lines released at time zero, so the pull-ups hold them high
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // ==========================================================
    // framing
    // start or repeated start: data falls while the clock is high
    task automatic start();
        #Q sda_low = 1'b0;
        #Q scl_low = 1'b0;
        #Q sda_low = 1'b1;
        #Q scl_low = 1'b1;
    endtask
    // stop: data rises while the clock is high, then the bus is free
    task automatic stop();
        #Q sda_low = 1'b1;
        #Q scl_low = 1'b0;
        #Q sda_low = 1'b0;
        #Q;
    endtask
    // one bit: data changes mid-low, sampled mid-high; a held clock is waited out
    task automatic bit_io(input logic b, output logic s);
        #Q sda_low = !b;
        #Q scl_low = 1'b0;
        wait (scl === 1'b1);
        #Q s = sda;
        #Q scl_low = 1'b1;
    endtask
    // ==========================================================
    // bytes, msb first
    // send a byte, then release data and read the acknowledge slot
    task automatic wbyte(input logic [7:0] b, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, nack);
    endtask
    // take a byte with data released, then acknowledge or not
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(nack, s);
    endtask
endmodule // smcr_master

/* File: smcr_pkg.sv */
// package: constants and types of the management bus register slave
package smcr_pkg;
    // ==========================================================
    // address, command and port constants
    localparam logic [3:0] SMCR_ADDR_FIXED = 4'h7; // address bits 6..3 = 0111
    localparam logic [7:0] SMCR_CMD_CODE = 8'h08;
    localparam logic [7:0] SMCR_NUM_PORTS = 8'h04;
    localparam logic [3:0] SMCR_BYTE_BITS = 4'h8;
    localparam logic [2:0] SMCR_IDX_ADDR = 3'h0;
    localparam logic [2:0] SMCR_IDX_CMD = 3'h1;
    localparam logic [2:0] SMCR_IDX_B2 = 3'h2;
    localparam logic [2:0] SMCR_IDX_B3 = 3'h3;
    localparam logic [2:0] SMCR_IDX_RD_LO = 3'h4;
    localparam logic [2:0] SMCR_IDX_RD_HI = 3'h5;
    localparam logic [7:0] SMCR_IDLE_BYTE = 8'hff;
    localparam logic [4:0] SMCR_PIN_RESET = 5'h03; // {strap, sda, scl}, lines idle high
    localparam logic [15:0] SMCR_REG_RESET = 16'h0000;
    // ==========================================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_RACK = 3'b010,
        ST_TX = 3'b011,
        ST_TACK = 3'b100,
        ST_SKIP = 3'b101
    } smcr_state_e;
    typedef struct packed {
        smcr_state_e state;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [2:0] nbyte;
        logic sel;
        logic ptr_done;
        logic data_phase;
        logic [7:0] offset;
        logic [7:0] port;
        logic [7:0] d1;
        logic [7:0] txbyte;
        logic sda_oe;
    } smcr_ctl_s;
    typedef struct packed {
        logic valid;
        logic [1:0] port;
        logic [7:0] offset;
        logic [15:0] data;
    } smcr_wr_s;
endpackage

/* File: smcr_slave.sv */
// module: management bus slave giving access to per-port config registers
`timescale 1ns/1ps
module smcr_slave (
    input wire logic clock,
    input wire logic rst,
    input wire logic mgmt_bus_clock_pin_in,
    output logic mgmt_bus_clock_pin_out,
    output logic mgmt_bus_clock_pin_oe,
    input wire logic mgmt_bus_data_pin_in,
    output logic mgmt_bus_data_pin_out,
    output logic mgmt_bus_data_pin_oe,
    input wire logic [2:0] addr_strap,
    output smcr_pkg::smcr_wr_s cfg_wr
);
    import smcr_pkg::*;

    // ==========================================================
    // pin synchronisers
    logic [4:0] pin_s0; // first stage, read only by pin_s1
    logic [4:0] pin_s1; // synced {strap, sda, scl}
    logic [1:0] pin_q; // previous synced sda/scl for edges
    logic scl_r; // bus clock rising
    logic scl_f; // bus clock falling
    logic start_c; // start or repeated start
    logic stop_c; // stop condition
    logic [6:0] my_addr; // own slave address

    // two flops on every pin before any logic looks at it
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pin_s0 <= SMCR_PIN_RESET;
            pin_s1 <= SMCR_PIN_RESET;
            pin_q <= SMCR_PIN_RESET[1:0];
        end
        else
        begin
            pin_s0 <= {addr_strap, mgmt_bus_data_pin_in, mgmt_bus_clock_pin_in};
            pin_s1 <= pin_s0;
            pin_q <= pin_s1[1:0];
        end
    end

    assign scl_r = pin_s1[0] & ~pin_q[0];
    assign scl_f = ~pin_s1[0] & pin_q[0];
    // data moving while clock high marks a frame boundary
    assign start_c = pin_s1[0] & pin_q[0] & ~pin_s1[1] & pin_q[1];
    assign stop_c = pin_s1[0] & pin_q[0] & pin_s1[1] & ~pin_q[1];
    assign my_addr = {SMCR_ADDR_FIXED, pin_s1[4:2]};

    // ==========================================================
    // register store: four ports of 128 words each
    logic [15:0] mem [0:511]; // any offset, ro or rw, lives here
    logic [15:0] rd_word; // word under the current pointer
    logic port_ok; // port byte in the valid range
    smcr_ctl_s ctl; // engine state, also read by the store lookup
    smcr_ctl_s next_ctl;

    // offset bit 0 picks no half: words sit at even offsets
    function automatic logic [8:0] word_idx(input logic [7:0] prt, input logic [7:0] off);
        word_idx = {prt[1:0], off[7:1]};
    endfunction

    assign port_ok = (ctl.port < SMCR_NUM_PORTS);
    // reserved ports read back as zero
    assign rd_word = port_ok ? mem[word_idx(ctl.port, ctl.offset)] : SMCR_REG_RESET;

    // ==========================================================
    // protocol engine
    smcr_wr_s next_wr; // one-cycle register write strobe
    logic byte_end; // falling edge closing the eighth bit
    logic [7:0] rx_byte; // byte just received

    assign byte_end = scl_f & (ctl.bitcnt == SMCR_BYTE_BITS);
    assign rx_byte = ctl.shreg;

    // next values: start/stop first, then the per-state bit handling
    always_comb
    begin
        next_ctl = ctl;
        next_wr = '0;
        if (start_c)
        begin
            // repeated start keeps the pointer and selection
            next_ctl.state = ST_RX;
            next_ctl.bitcnt = '0;
            next_ctl.nbyte = SMCR_IDX_ADDR;
            next_ctl.sda_oe = 1'b0;
        end
        else if (stop_c)
        begin
            // pointer survives only a transaction that set it or one for another address
            if (ctl.sel)
            begin
                next_ctl.data_phase = ctl.ptr_done;
            end
            next_ctl.state = ST_IDLE;
            next_ctl.sel = 1'b0;
            next_ctl.ptr_done = 1'b0;
            next_ctl.sda_oe = 1'b0;
        end
        else
        begin
            case (ctl.state)
                ST_RX:
                begin
                    if (scl_r)
                    begin
                        next_ctl.shreg = {ctl.shreg[6:0], pin_s1[1]};
                        next_ctl.bitcnt = ctl.bitcnt + 4'h1;
                    end
                    else if (byte_end)
                    begin
                        next_ctl.state = ST_RACK;
                        next_ctl.sda_oe = 1'b1; // ack unless refused below
                        // bytes past the fourth park on the high index, never read as a send
                        if (ctl.nbyte < SMCR_IDX_RD_LO)
                        begin
                            next_ctl.nbyte = (ctl.nbyte == SMCR_IDX_B3) ?
                                SMCR_IDX_RD_HI : ctl.nbyte + 3'h1;
                        end
                        case (ctl.nbyte)
                            SMCR_IDX_ADDR:
                            begin
                                if (rx_byte[7:1] != my_addr)
                                begin
                                    next_ctl.sda_oe = 1'b0;
                                    next_ctl.state = ST_SKIP;
                                end
                                else if (rx_byte[0])
                                begin
                                    // read only after a pointer was set
                                    next_ctl.sel = 1'b1;
                                    next_ctl.sda_oe = ctl.data_phase;
                                    next_ctl.state = ctl.data_phase ? ST_RACK : ST_SKIP;
                                    next_ctl.txbyte = rd_word[7:0];
                                    next_ctl.nbyte = SMCR_IDX_RD_LO;
                                end
                                else
                                begin
                                    next_ctl.sel = 1'b1;
                                end
                            end
                            SMCR_IDX_CMD:
                            begin
                                if (rx_byte != SMCR_CMD_CODE)
                                begin
                                    next_ctl.sda_oe = 1'b0;
                                    next_ctl.state = ST_SKIP;
                                end
                            end
                            SMCR_IDX_B2:
                            begin
                                if (ctl.data_phase)
                                begin
                                    next_ctl.d1 = rx_byte;
                                end
                                else
                                begin
                                    next_ctl.offset = rx_byte;
                                end
                            end
                            SMCR_IDX_B3:
                            begin
                                if (ctl.data_phase)
                                begin
                                    // reserved port: acked but nothing stored
                                    next_wr.valid = port_ok;
                                    next_wr.port = ctl.port[1:0];
                                    next_wr.offset = ctl.offset;
                                    next_wr.data = {rx_byte, ctl.d1};
                                end
                                else
                                begin
                                    next_ctl.port = rx_byte;
                                    next_ctl.ptr_done = 1'b1;
                                end
                            end
                            default:
                            begin
                                // no checksum byte is expected
                                next_ctl.sda_oe = 1'b0;
                                next_ctl.state = ST_SKIP;
                            end
                        endcase
                    end
                end
                ST_RACK:
                begin
                    // ack bit ends on the ninth falling edge
                    if (scl_f)
                    begin
                        next_ctl.bitcnt = '0;
                        if (ctl.nbyte == SMCR_IDX_RD_LO)
                        begin
                            next_ctl.state = ST_TX;
                            next_ctl.sda_oe = ~ctl.txbyte[7];
                        end
                        else
                        begin
                            next_ctl.state = ST_RX;
                            next_ctl.sda_oe = 1'b0;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_r)
                    begin
                        next_ctl.bitcnt = ctl.bitcnt + 4'h1;
                    end
                    else if (byte_end)
                    begin
                        next_ctl.sda_oe = 1'b0; // let the master ack
                        next_ctl.state = ST_TACK;
                    end
                    else if (scl_f)
                    begin
                        next_ctl.txbyte = {ctl.txbyte[6:0], 1'b1};
                        next_ctl.sda_oe = ~ctl.txbyte[6];
                    end
                end
                ST_TACK:
                begin
                    if (scl_r)
                    begin
                        next_ctl.shreg = {7'h00, pin_s1[1]}; // master ack level
                    end
                    else if (scl_f)
                    begin
                        next_ctl.bitcnt = '0;
                        if (ctl.shreg[0])
                        begin
                            next_ctl.state = ST_SKIP;
                        end
                        else
                        begin
                            // past the high byte only released ones go out
                            next_ctl.txbyte = (ctl.nbyte == SMCR_IDX_RD_LO) ?
                                rd_word[15:8] : SMCR_IDLE_BYTE;
                            next_ctl.nbyte = SMCR_IDX_RD_HI;
                            next_ctl.sda_oe = (ctl.nbyte == SMCR_IDX_RD_LO) ?
                                ~rd_word[15] : 1'b0;
                            next_ctl.state = ST_TX;
                        end
                    end
                end
                ST_SKIP:
                begin
                    next_ctl.sda_oe = 1'b0; // wait for start or stop
                end
                default:
                begin
                    next_ctl.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // registers only; the bus clock line is never driven
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ctl <= '0;
            cfg_wr <= '0;
            mgmt_bus_clock_pin_oe <= 1'b0;
            mgmt_bus_clock_pin_out <= 1'b0;
            mgmt_bus_data_pin_out <= 1'b0;
        end
        else
        begin
            ctl <= next_ctl;
            cfg_wr <= next_wr;
            mgmt_bus_clock_pin_oe <= 1'b0;
            mgmt_bus_clock_pin_out <= 1'b0;
            mgmt_bus_data_pin_out <= 1'b0;
        end
    end

    assign mgmt_bus_data_pin_oe = ctl.sda_oe; // straight from a flop

    // store is written even for read-only registers, no reset on the array
    always_ff @(posedge clock)
    begin
        if (next_wr.valid)
        begin
            mem[word_idx({6'h00, next_wr.port}, next_wr.offset)] <= next_wr.data;
        end
    end

    // ==========================================================
    // assertions
    a_clk_never_driven: assert property (@(posedge clock) disable iff (rst)
        !mgmt_bus_clock_pin_oe) else $error("clock line driven");
    a_drive_only_ack: assert property (@(posedge clock) disable iff (rst)
        ctl.sda_oe |-> (ctl.state == ST_RACK || ctl.state == ST_TX))
        else $error("data driven outside ack or data");
    a_addr_mismatch: assert property (@(posedge clock) disable iff (rst)
        (ctl.state == ST_RX && byte_end && ctl.nbyte == SMCR_IDX_ADDR && !start_c
        && !stop_c && rx_byte[7:1] != my_addr) |=> (ctl.state == ST_SKIP && !ctl.sda_oe))
        else $error("foreign address answered");
    a_cmd_refused: assert property (@(posedge clock) disable iff (rst)
        (ctl.state == ST_RX && byte_end && ctl.nbyte == SMCR_IDX_CMD && !start_c
        && !stop_c && rx_byte != SMCR_CMD_CODE) |=> ctl.state == ST_SKIP)
        else $error("bad command accepted");
    a_offset_latch: assert property (@(posedge clock) disable iff (rst)
        (ctl.state == ST_RX && byte_end && ctl.nbyte == SMCR_IDX_B2 && !ctl.data_phase
        && !start_c && !stop_c) |=> ctl.offset == $past(rx_byte))
        else $error("offset not latched");
    a_wr_data: assert property (@(posedge clock) disable iff (rst)
        cfg_wr.valid |-> (cfg_wr.data == {$past(rx_byte), ctl.d1}
        && cfg_wr.offset == ctl.offset)) else $error("write word misassembled");
    a_rsv_port: assert property (@(posedge clock) disable iff (rst)
        cfg_wr.valid |-> $past(ctl.port) < SMCR_NUM_PORTS)
        else $error("reserved port written");
    a_ack_release: assert property (@(posedge clock) disable iff (rst)
        (ctl.state == ST_RACK && scl_f && ctl.nbyte != SMCR_IDX_RD_LO && !start_c
        && !stop_c) |=> !ctl.sda_oe ##1 !ctl.sda_oe) else $error("ack held too long");
    a_extra_nack: assert property (@(posedge clock) disable iff (rst)
        (ctl.state == ST_RX && byte_end && ctl.nbyte == SMCR_IDX_RD_HI && !start_c
        && !stop_c) |=> !ctl.sda_oe) else $error("extra byte acked");
    c_write_done: cover property (@(posedge clock) disable iff (rst) cfg_wr.valid);
    c_read_sent: cover property (@(posedge clock) disable iff (rst)
        ctl.state == ST_TACK && ctl.nbyte == SMCR_IDX_RD_HI);
    c_addr_skip: cover property (@(posedge clock) disable iff (rst)
        ctl.state == ST_SKIP && !ctl.sel);
endmodule // smcr_slave

/* File: tb_top.sv */
// testbench: management bus register slave against a bus master model
`timescale 1ns/1ps
module tb_top;
    import smcr_pkg::*;
    // ==========================================================
    // clock, reset and open-drain wiring with pull-ups
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr_strap = 3'h0;
    logic clk_out, clk_oe, dat_out, dat_oe, m_scl_low, m_sda_low;
    wire scl = !(m_scl_low || (clk_oe && !clk_out));
    wire sda = !(m_sda_low || (dat_oe && !dat_out));
    smcr_wr_s cfg_wr;
    smcr_wr_s last_wr;
    int n_fail = 0;
    int checks = 0;
    int n_wr = 0;
    int cycles = 0;
    always #5 clock = !clock;
    smcr_slave u_dut (.clock(clock), .rst(rst), .mgmt_bus_clock_pin_in(scl),
        .mgmt_bus_clock_pin_out(clk_out), .mgmt_bus_clock_pin_oe(clk_oe),
        .mgmt_bus_data_pin_in(sda), .mgmt_bus_data_pin_out(dat_out),
        .mgmt_bus_data_pin_oe(dat_oe), .addr_strap(addr_strap), .cfg_wr(cfg_wr));
    smcr_master u_master (.scl(scl), .sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low));
    // ==========================================================
    // report helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================================
    // monitors: write strobes, clock line never pulled, hang limit
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cfg_wr.valid === 1'b1)
        begin
            n_wr <= n_wr + 1;
            last_wr <= cfg_wr;
        end
        // slave only: it must never drive the clock line
        if (!rst && clk_oe !== 1'b0)
            check("clock_oe", 32'(clk_oe), 32'h0);
        // limit is nearly three times the expected run, so slow slaves still finish
        if (cycles == 80000)
        begin
            n_fail = n_fail + 1;
            finish_test();
        end
    end
    // ==========================================================
    // bus transactions
    // address, command 08h, two bytes, stop; nack slots returned msb first
    task automatic txn(input logic [6:0] a, input logic [7:0] b2, input logic [7:0] b3,
        output logic [3:0] nk);
        u_master.start();
        u_master.wbyte({a, 1'b0}, nk[3]);
        u_master.wbyte(8'h08, nk[2]);
        u_master.wbyte(b2, nk[1]);
        u_master.wbyte(b3, nk[0]);
        u_master.stop();
    endtask
    // command phase, repeated start, read low then high byte
    task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic [2:0] nk);
        u_master.start();
        u_master.wbyte({a, 1'b0}, nk[2]);
        u_master.wbyte(8'h08, nk[1]);
        u_master.start();
        u_master.wbyte({a, 1'b1}, nk[0]);
        u_master.rbyte(1'b0, d[7:0]);
        u_master.rbyte(1'b1, d[15:8]);
        u_master.stop();
    endtask
    // ==========================================================
    // scenarios
    // write then read back one word in every port
    task automatic s_ports();
        logic [3:0] nk;
        logic [2:0] rk;
        logic [15:0] d;
        int n0;
        for (int p = 0; p < 4; p++)
        begin
            n0 = n_wr;
            txn(7'h38, 8'hb4 + 8'(2 * p), 8'(p), nk);
            check("ptr_nack", 32'(nk), 32'h0);
            txn(7'h38, 8'h34, 8'h12 + 8'(p), nk);
            check("dat_nack", 32'(nk), 32'h0);
            check("wr_count", 32'(n_wr - n0), 32'h1);
            check("wr_port", 32'(last_wr.port), 32'(p));
            check("wr_offset", 32'(last_wr.offset), 32'(8'hb4 + 8'(2 * p)));
            check("wr_data", 32'(last_wr.data), 32'(16'h1234 + 16'(256 * p)));
            txn(7'h38, 8'hb4 + 8'(2 * p), 8'(p), nk);
            rd(7'h38, d, rk);
            check("rd_nack", 32'(rk), 32'h0);
            check("rd_data", 32'(d), 32'(16'h1234 + 16'(256 * p)));
        end
    endtask
    // every strap value; foreign addresses get no answer at all
    task automatic s_strap();
        logic [3:0] nk;
        int n0;
        for (int s = 0; s < 8; s++)
        begin
            @(posedge clock);
            #1 addr_strap = 3'(s);
            repeat (4) @(posedge clock);
            n0 = n_wr;
            txn({4'h7, ~3'(s)}, 8'h10, 8'h02, nk);
            check("other_addr", 32'(nk), 32'hf);
            txn({4'hf, 3'(s)}, 8'h10, 8'h02, nk);
            check("bit6_addr", 32'(nk), 32'hf);
            txn({4'h7, 3'(s)}, 8'h10, 8'h02, nk);
            txn({4'h7, 3'(s)}, 8'(s), 8'ha5, nk);
            check("strap_nack", 32'(nk), 32'h0);
            check("strap_wr", 32'(n_wr - n0), 32'h1);
            check("strap_data", 32'(last_wr.data), 32'({8'ha5, 8'(s)}));
        end
        @(posedge clock);
        #1 addr_strap = 3'h0;
        repeat (4) @(posedge clock);
    endtask
    // first reserved port value: write dropped, read returns zero
    task automatic s_reserved();
        logic [3:0] nk;
        logic [2:0] rk;
        logic [15:0] d;
        int n0;
        n0 = n_wr;
        txn(7'h38, 8'h20, 8'h04, nk);
        txn(7'h38, 8'hcd, 8'hab, nk);
        check("rsv_wr", 32'(n_wr - n0), 32'h0);
        txn(7'h38, 8'h20, 8'h04, nk);
        rd(7'h38, d, rk);
        check("rsv_rd", 32'(d), 32'h0);
    endtask
    // bad command and extra byte refused; read with a spent pointer refused
    task automatic s_refuse();
        logic [3:0] nk;
        logic [2:0] rk;
        logic [15:0] d;
        logic x;
        u_master.start();
        u_master.wbyte(8'h70, x);
        u_master.wbyte(8'h09, x);
        u_master.stop();
        check("cmd_nack", 32'(x), 32'h1);
        txn(7'h38, 8'h40, 8'h02, nk);
        u_master.start();
        u_master.wbyte(8'h70, x);
        u_master.wbyte(8'h08, x);
        u_master.wbyte(8'h78, x);
        u_master.wbyte(8'h56, x);
        u_master.wbyte(8'h99, x);
        u_master.stop();
        check("extra_nack", 32'(x), 32'h1);
        check("extra_data", 32'(last_wr.data), 32'h5678);
        txn(7'h38, 8'h40, 8'h02, nk);
        rd(7'h38, d, rk);
        check("ro_rd", 32'(d), 32'h5678);
        rd(7'h38, d, rk);
        check("nop_rd", 32'(rk), 32'h1);
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        repeat (6) @(posedge clock);
        #1 rst = 1'b0;
        repeat (5) @(posedge clock);
        s_ports();
        s_strap();
        s_reserved();
        s_refuse();
        check("dat_out", 32'(dat_out), 32'h0);
        check("clk_out", 32'(clk_out), 32'h0);
        finish_test();
    end
endmodule // tb_top
